/* File: rtl/pic_cfg.svh */
// constants for the prioritized interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_NUM_SRC 10
`define PIC_NUM_EXT 4
`define PIC_NUM_INT 6
`define PIC_SRC_SLOT 0
`define PIC_SRC_LINE3 1
`define PIC_SRC_BRIDGE 2
`define PIC_SRC_ABORT 3
`define PIC_SRC_FIRST_TIMER 4
`define PIC_SRC_WATCHDOG 6
`define PIC_LEVEL_TOP 3'h7
`define PIC_ABORT_PRIO 2'h3
`define PIC_MASK_MSB 10
`define PIC_MASK_LSB 8
`define PIC_AUTOVEC_BASE 8'h18
`define PIC_WDT_CLOCKS_00 1024
`define PIC_RST_LEVEL 3'h0
`define PIC_RST_VECTOR 8'h00
`define PIC_RST_ADDR 32'h0000_0000
`endif

/* File: rtl/pic_pkg.sv */
// types shared by the prioritized interrupt controller
package pic_pkg;
	typedef struct packed {
		logic [2:0] level;
		logic [1:0] prio;
		logic autovec;
	} pic_src_cfg_t;
	typedef struct packed {
		logic [1:0] prio;
		logic autovec;
	} pic_ext_cfg_t;
	typedef enum logic [0:0] {
		PIC_IDLE,
		PIC_ACK
	} pic_state_t;
endpackage

/* File: rtl/pic_controller.sv */
// prioritized interrupt controller with acknowledge and vector generation
// Functional notes
// [RULE1] seven levels 1..7; the highest pending level is shown to the core
// [RULE2] a request above the status word mask is acknowledged after the instruction ends
// [RULE3] a vectored source supplies its vector number during acknowledge
// [RULE4] autovectored sources get an internally generated vector per level
// [RULE5] four active-low external lines, level set 1,3,5,7 or 2,4,6,7
// [RULE6] board set-up selects levels 1,3,5,7 for the external lines
// [RULE7] six internal sources: two timers, watchdog, two serial channels, two-wire
// [RULE8] any internal source takes any level, plus relative priority 0..3
// [RULE9] set-up puts the watchdog at level 7, priority 2, vectored
// [RULE10] set-up puts serial channels and two-wire at level 3, autovector, priorities 2,1,0
// [RULE11] set-up puts timers at level 5, autovector, priorities 3 and 2
// [RULE12] software never gives two sources the same level and priority
// [RULE13] abort line is non-maskable level 7 priority 3, autovectored
// [RULE14] line 1 comes from the slot interrupt, line 5 from the bridge
// [RULE15] the mask sits in the 16-bit status word
// [RULE16] handler address is the vector base pointer plus four times the vector
// [RULE17] timeout select 00 gives 1024 clocks; watchdog off unless enabled
// [RULE18] highest level first, then highest relative priority
// [RULE19] level 7 is taken even when the mask is 7
`timescale 1ns/1ns
`default_nettype none
`include "pic_cfg.svh"
module pic_controller
	import pic_pkg::*;
#(
	parameter int WDT_CLOCKS_01 = 8192,
	parameter int WDT_CLOCKS_10 = 32768,
	parameter int WDT_CLOCKS_11 = 65536
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// external request lines, active low
	input wire logic slot_request_line_n,
	input wire logic level3_request_line_n,
	input wire logic bridge_request_line_n,
	input wire logic abort_request_line_n,
	input wire logic ext_level_set,
	input wire pic_ext_cfg_t [2:0] ext_cfg,
	// internal sources and their configuration
	input wire logic first_timer_req,
	input wire logic second_timer_req,
	input wire logic first_serial_channel_req,
	input wire logic second_serial_channel_req,
	input wire logic two_wire_module_req,
	input wire pic_src_cfg_t [5:0] int_cfg,
	// watchdog control
	input wire logic watchdog_enable,
	input wire logic [1:0] watchdog_timeout_select,
	input wire logic watchdog_service,
	// core side
	input wire logic [15:0] processor_status_word,
	input wire logic [31:0] vector_base_pointer,
	input wire logic instr_done,
	// vector answer from a vectored source
	input wire logic src_vec_valid,
	input wire logic [7:0] src_vector,
	// outputs
	output logic [2:0] pending_level,
	output logic iack_active,
	output logic [2:0] iack_level,
	output logic [`PIC_NUM_SRC-1:0] iack_grant,
	output logic vector_valid,
	output logic [7:0] vector_num,
	output logic [31:0] handler_addr,
	output logic watchdog_timeout
);
	logic [`PIC_NUM_SRC-1:0] req;
	logic [`PIC_NUM_SRC-1:0] elig;
	pic_src_cfg_t [`PIC_NUM_SRC-1:0] cfg;
	logic [2:0] mask;
	logic best_found;
	logic [3:0] best_idx;
	logic [4:0] best_key;
	pic_state_t state, next_state;
	logic ack_auto, next_ack_auto;
	logic next_iack_active, next_vector_valid;
	logic [2:0] next_iack_level, next_pending_level;
	logic [`PIC_NUM_SRC-1:0] next_iack_grant;
	logic [7:0] next_vector_num;
	logic [31:0] next_handler_addr;
	logic [16:0] wdt_cnt, next_wdt_cnt, wdt_limit;
	logic next_watchdog_timeout;

	// mask field of the 16-bit status word
	assign mask = processor_status_word[`PIC_MASK_MSB:`PIC_MASK_LSB]; // see [RULE15]

	// request vector, external lines are active low
	assign req = {two_wire_module_req, second_serial_channel_req, first_serial_channel_req,
		watchdog_timeout, second_timer_req, first_timer_req,
		~abort_request_line_n, ~bridge_request_line_n, ~level3_request_line_n,
		~slot_request_line_n}; // see [RULE7] see [RULE14]

	// per-source configuration and eligibility against the mask
	for (genvar i = 0; i < `PIC_NUM_SRC; i++) begin : g_src
		if (i == `PIC_SRC_ABORT) begin : g_abort
			// abort switch cannot answer with a vector, so it is fixed autovector
			assign cfg[i] = '{level: `PIC_LEVEL_TOP, prio: `PIC_ABORT_PRIO, autovec: 1'b1}; // see [RULE13]
		end else if (i < `PIC_NUM_EXT) begin : g_ext
			// line k sits at 2k+1 or 2k+2 depending on the level set
			assign cfg[i] = '{level: 3'(2 * i + 1) + {2'h0, ext_level_set},
				prio: ext_cfg[i].prio, autovec: ext_cfg[i].autovec}; // see [RULE5]
		end else begin : g_int
			assign cfg[i] = int_cfg[i - `PIC_NUM_EXT]; // see [RULE8]
		end
		// level 7 ignores the mask so it can never be blocked
		assign elig[i] = req[i] && (cfg[i].level != 3'h0) &&
			((cfg[i].level > mask) || (cfg[i].level == `PIC_LEVEL_TOP)); // see [RULE2] see [RULE19]
	end

	// pick the highest level, then the highest relative priority
	always_comb begin
		best_found = 1'b0;
		best_idx = 4'h0;
		best_key = 5'h00;
		for (int i = 0; i < `PIC_NUM_SRC; i++) begin
			// ties keep the lower index; equal pairs are a software fault anyway
			if (elig[i] && (!best_found || {cfg[i].level, cfg[i].prio} > best_key)) begin
				best_found = 1'b1;
				best_idx = 4'(i);
				best_key = {cfg[i].level, cfg[i].prio}; // see [RULE18]
			end
		end
	end

	// acknowledge sequence next values
	always_comb begin
		next_state = state;
		next_ack_auto = ack_auto;
		next_iack_active = iack_active;
		next_iack_level = iack_level;
		next_iack_grant = iack_grant;
		next_vector_num = vector_num;
		next_handler_addr = handler_addr;
		next_vector_valid = 1'b0;
		next_pending_level = best_found ? best_key[4:2] : 3'h0; // see [RULE1]
		case (state)
			PIC_IDLE: begin
				// only between instructions, so the current one always completes
				if (instr_done && best_found) begin
					next_state = PIC_ACK;
					next_iack_active = 1'b1;
					next_iack_level = best_key[4:2];
					next_iack_grant = '0;
					next_iack_grant[best_idx] = 1'b1;
					next_ack_auto = cfg[best_idx].autovec; // see [RULE2]
				end
			end
			PIC_ACK: begin
				if (ack_auto || src_vec_valid) begin
					if (ack_auto) begin
						next_vector_num = `PIC_AUTOVEC_BASE + {5'h00, iack_level}; // see [RULE4]
					end else begin
						next_vector_num = src_vector; // see [RULE3]
					end
					next_handler_addr = vector_base_pointer +
						{22'h000000, next_vector_num, 2'h0}; // see [RULE16]
					next_vector_valid = 1'b1;
					next_iack_active = 1'b0;
					next_iack_grant = '0;
					next_state = PIC_IDLE;
				end
			end
			default: begin
				next_state = PIC_IDLE;
				next_iack_active = 1'b0;
				next_iack_grant = '0;
			end
		endcase
	end

	// acknowledge sequence registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= PIC_IDLE;
			ack_auto <= 1'b0;
			iack_active <= 1'b0;
			iack_level <= `PIC_RST_LEVEL;
			iack_grant <= '0;
			vector_num <= `PIC_RST_VECTOR;
			handler_addr <= `PIC_RST_ADDR;
			vector_valid <= 1'b0;
			pending_level <= `PIC_RST_LEVEL;
		end else begin
			state <= next_state;
			ack_auto <= next_ack_auto;
			iack_active <= next_iack_active;
			iack_level <= next_iack_level;
			iack_grant <= next_iack_grant;
			vector_num <= next_vector_num;
			handler_addr <= next_handler_addr;
			vector_valid <= next_vector_valid;
			pending_level <= next_pending_level;
		end
	end

	// watchdog timeout length per select value
	always_comb begin
		case (watchdog_timeout_select)
			2'h0: wdt_limit = 17'(`PIC_WDT_CLOCKS_00); // see [RULE17]
			2'h1: wdt_limit = 17'(WDT_CLOCKS_01);
			2'h2: wdt_limit = 17'(WDT_CLOCKS_10);
			default: wdt_limit = 17'(WDT_CLOCKS_11);
		endcase
	end

	// watchdog count; a timeout in the service cycle still raises the flag
	always_comb begin
		next_wdt_cnt = wdt_cnt;
		next_watchdog_timeout = watchdog_timeout;
		if (!watchdog_enable) begin
			next_wdt_cnt = 17'h00000; // see [RULE17]
			next_watchdog_timeout = 1'b0;
		end else begin
			if (watchdog_service) begin
				next_wdt_cnt = 17'h00000;
				next_watchdog_timeout = 1'b0;
			end else begin
				next_wdt_cnt = wdt_cnt + 17'h00001;
			end
			if (wdt_cnt + 17'h00001 >= wdt_limit) begin
				next_wdt_cnt = 17'h00000;
				next_watchdog_timeout = 1'b1;
			end
		end
	end

	// watchdog registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wdt_cnt <= 17'h00000;
			watchdog_timeout <= 1'b0;
		end else begin
			wdt_cnt <= next_wdt_cnt;
			watchdog_timeout <= next_watchdog_timeout;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_pending_level;
		best_found |=> pending_level == $past(best_key[4:2]);
	endproperty
	a_pending_level: assert property (p_pending_level) else $error("pending level wrong"); // see [RULE1]
	property p_take;
		(state == PIC_IDLE) && instr_done && best_found |=> iack_active && $onehot(iack_grant);
	endproperty
	a_take: assert property (p_take) else $error("acknowledge not started"); // see [RULE2]
	property p_wait_instr;
		(state == PIC_IDLE) && !instr_done |=> !iack_active;
	endproperty
	a_wait_instr: assert property (p_wait_instr) else $error("acknowledge mid instruction"); // see [RULE2]
	property p_level_ok;
		$rose(iack_active) |-> (iack_level > $past(mask)) || (iack_level == `PIC_LEVEL_TOP);
	endproperty
	a_level_ok: assert property (p_level_ok) else $error("masked level taken"); // see [RULE19]
	property p_autovec;
		iack_active && ack_auto |=> vector_valid && vector_num == `PIC_AUTOVEC_BASE + {5'h00, $past(iack_level)};
	endproperty
	a_autovec: assert property (p_autovec) else $error("autovector wrong"); // see [RULE4]
	property p_vectored;
		iack_active && !ack_auto && src_vec_valid |=> vector_valid && vector_num == $past(src_vector);
	endproperty
	a_vectored: assert property (p_vectored) else $error("supplied vector lost"); // see [RULE3]
	property p_handler;
		vector_valid |-> handler_addr == $past(vector_base_pointer) + {22'h000000, vector_num, 2'h0};
	endproperty
	a_handler: assert property (p_handler) else $error("handler address wrong"); // see [RULE16]
	property p_abort;
		(state == PIC_IDLE) && instr_done && !abort_request_line_n |=> iack_level == `PIC_LEVEL_TOP;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not at level 7"); // see [RULE13]
	property p_wdt_off;
		!watchdog_enable [*2] |-> !watchdog_timeout && wdt_cnt == 17'h00000;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog active while off"); // see [RULE17]
	c_auto: cover property (iack_active && ack_auto ##1 vector_valid);
	c_vectored: cover property (iack_active && !ack_auto ##1 iack_active ##1 vector_valid);
	c_abort_masked: cover property (mask == 3'h7 && !abort_request_line_n && $rose(iack_active));
	c_wdt: cover property ($rose(watchdog_timeout));
endmodule
`default_nettype wire

/* File: sim/pic_vec_source.sv */
// vectored interrupt source that answers acknowledge cycles
`timescale 1ns/1ns
`default_nettype none
module pic_vec_source #(
	parameter int WATCH = 6,
	parameter logic [7:0] VECTOR = 8'h40
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// latency choice and acknowledge view
	input wire logic slow,
	input wire logic iack_active,
	input wire logic [9:0] iack_grant,
	// vector answer
	output logic src_vec_valid,
	output logic [7:0] src_vector
);
	int wait_cnt;
	// answer our own grant only; the bus toggles while released, so after an answer a stale value matches the vector every other cycle
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			src_vec_valid <= 1'b0;
			src_vector <= 8'hFF;
			wait_cnt <= 0;
		end else if (iack_active && iack_grant[WATCH]) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= (slow ? 5 : 0)) begin
				src_vec_valid <= 1'b1;
				src_vector <= VECTOR;
			end
		end else begin
			src_vec_valid <= 1'b0;
			src_vector <= ~src_vector;
			wait_cnt <= 0;
		end
	end
endmodule
`default_nettype wire

/* File: sim/prioritized_interrupt_controller_tb_top.sv */
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ns
`default_nettype none
module prioritized_interrupt_controller_tb_top;
	import pic_pkg::*;
	logic core_clk, resetn, instr_done, ext_level_set, wd_en, wd_svc, slow;
	logic [1:0] wd_sel;
	logic [3:0] ext_n;
	logic [4:0] int_req;
	pic_ext_cfg_t [2:0] ext_cfg;
	pic_src_cfg_t [5:0] int_cfg;
	logic [15:0] psw;
	logic [31:0] vbp, handler_addr;
	logic [7:0] src_vector, vector_num;
	logic [2:0] pending_level, iack_level;
	logic [9:0] iack_grant;
	logic iack_active, vector_valid, wd_timeout, src_vec_valid;
	int errors, checks_done;
	pic_controller i_dut (.core_clk(core_clk), .resetn(resetn),
		.slot_request_line_n(ext_n[0]), .level3_request_line_n(ext_n[1]),
		.bridge_request_line_n(ext_n[2]), .abort_request_line_n(ext_n[3]),
		.ext_level_set(ext_level_set), .ext_cfg(ext_cfg),
		.first_timer_req(int_req[0]), .second_timer_req(int_req[1]),
		.first_serial_channel_req(int_req[2]), .second_serial_channel_req(int_req[3]),
		.two_wire_module_req(int_req[4]), .int_cfg(int_cfg), .watchdog_enable(wd_en),
		.watchdog_timeout_select(wd_sel), .watchdog_service(wd_svc),
		.processor_status_word(psw), .vector_base_pointer(vbp), .instr_done(instr_done),
		.src_vec_valid(src_vec_valid), .src_vector(src_vector),
		.pending_level(pending_level), .iack_active(iack_active), .iack_level(iack_level),
		.iack_grant(iack_grant), .vector_valid(vector_valid), .vector_num(vector_num),
		.handler_addr(handler_addr), .watchdog_timeout(wd_timeout));
	pic_vec_source i_vec_src (.core_clk(core_clk), .resetn(resetn), .slow(slow),
		.iack_active(iack_active), .iack_grant(iack_grant),
		.src_vec_valid(src_vec_valid), .src_vector(src_vector));
	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one instruction boundary, then follow the acknowledge to its vector
	task automatic take(input logic [7:0] vec, input int src, input logic [2:0] lvl);
		logic [9:0] g;
		logic [2:0] l;
		g = 10'h000;
		l = 3'h0;
		repeat (2) @(posedge core_clk);
		#1 check(pending_level, lvl, "pending level");
		@(posedge core_clk) instr_done <= 1'b1;
		@(posedge core_clk) instr_done <= 1'b0;
		for (int n = 0; n < 200; n++) begin
			#1;
			if (iack_active === 1'b1) begin
				g = iack_grant;
				l = iack_level;
			end
			if (vector_valid === 1'b1)
				break;
			@(posedge core_clk);
		end
		check(vector_valid, 1'b1, "vector pulse");
		check(g, 10'h001 << src, "grant");
		check(l, lvl, "ack level");
		check(vector_num, vec, "vector");
		check(handler_addr, vbp + {22'h000000, vec, 2'h0}, "handler");
	endtask
	// hang guard, far beyond the expected nine thousand four hundred cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		test_done;
	end
	// main sequence
	initial begin
		int s;
		resetn = 1'b0;
		instr_done = 1'b0;
		ext_level_set = 1'b0;
		wd_en = 1'b0;
		wd_sel = 2'h0;
		wd_svc = 1'b0;
		slow = 1'b0;
		ext_n = 4'hF;
		int_req = 5'h00;
		psw = 16'h0000;
		vbp = 32'h7FE0_0000;
		// board set-up with unique level and priority pairs
		ext_cfg[0] = '{2'h0, 1'b1};
		ext_cfg[1] = '{2'h3, 1'b1};
		ext_cfg[2] = '{2'h1, 1'b1};
		int_cfg[0] = '{3'h5, 2'h3, 1'b1};
		int_cfg[1] = '{3'h5, 2'h2, 1'b1};
		int_cfg[2] = '{3'h7, 2'h2, 1'b0};
		int_cfg[3] = '{3'h3, 2'h2, 1'b1};
		int_cfg[4] = '{3'h3, 2'h1, 1'b1};
		int_cfg[5] = '{3'h3, 2'h0, 1'b1};
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		// abort beats pending timers even under a full mask
		@(posedge core_clk) psw <= 16'h0700;
		ext_n[3] <= 1'b0;
		int_req <= 5'h03;
		take(8'h1F, 3, 3'h7);
		@(posedge core_clk) ext_n[3] <= 1'b1;
		vbp <= 32'h0000_0000;
		$display("test abort finished");
		// mask equal to the level holds requests off; a wrong take shows one edge after the boundary
		@(posedge core_clk) psw <= 16'h0500;
		@(posedge core_clk) instr_done <= 1'b1;
		@(posedge core_clk) instr_done <= 1'b0;
		#1 check(iack_active, 1'b0, "masked ack");
		repeat (6) @(posedge core_clk);
		#1 check(vector_num, 8'h1F, "masked vector");
		@(posedge core_clk) psw <= 16'h0400;
		take(8'h1D, 4, 3'h5);
		@(posedge core_clk) int_req[0] <= 1'b0;
		take(8'h1D, 5, 3'h5);
		@(posedge core_clk) int_req <= 5'h1C;
		psw <= 16'h0000;
		for (int i = 0; i < 3; i++) begin
			take(8'h1B, 7 + i, 3'h3);
			@(posedge core_clk) int_req[2 + i] <= 1'b0;
		end
		$display("test priority finished");
		// both level sets of the external lines
		for (s = 0; s < 2; s++) begin
			@(posedge core_clk) ext_level_set <= s[0];
			for (int i = 0; i < 3; i++) begin
				@(posedge core_clk) ext_n[i] <= 1'b0;
				take(8'h19 + 8'(2 * i + s), i, 3'(1 + 2 * i + s));
				@(posedge core_clk) ext_n[i] <= 1'b1;
			end
		end
		$display("test external lines finished");
		// watchdog timeout then vectored service, prompt and slow answer
		@(posedge core_clk) wd_en <= 1'b1;
		repeat (1010) @(posedge core_clk);
		#1 check(wd_timeout, 1'b0, "early timeout");
		for (s = 0; s < 30 && wd_timeout !== 1'b1; s++)
			@(posedge core_clk) #1;
		check(s >= 12 && s <= 16, 1'b1, "timeout moment");
		take(8'h40, 6, 3'h7);
		@(posedge core_clk) slow <= 1'b1;
		take(8'h40, 6, 3'h7);
		@(posedge core_clk) wd_svc <= 1'b1;
		wd_en <= 1'b0;
		@(posedge core_clk) wd_svc <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 check(wd_timeout, 1'b0, "serviced");
		// select 01 counts to its own longer limit of 8192 clocks
		@(posedge core_clk) wd_sel <= 2'h1;
		wd_en <= 1'b1;
		repeat (8178) @(posedge core_clk);
		#1 check(wd_timeout, 1'b0, "early long timeout");
		for (s = 0; s < 30 && wd_timeout !== 1'b1; s++)
			@(posedge core_clk) #1;
		check(s >= 12 && s <= 16, 1'b1, "long timeout moment");
		@(posedge core_clk) wd_en <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 check(wd_timeout, 1'b0, "disabled");
		$display("test watchdog finished");
		test_done;
	end
endmodule
`default_nettype wire
